/* include/field_fifo_consts.vh */
// constants for the field delay fifo core
`ifndef FIELD_FIFO_CONSTS_VH
`define FIELD_FIFO_CONSTS_VH

// word count 262144 needs an 18-bit address
`define FF_ADDR_W         18
`define FF_DATA_W         8
// address counter value after a clear or an init
`define FF_ADDR_RST       18'h0_0000
// reset cycles needed on each side before use
`define FF_RST_CYC_MIN    7'h64
`define FF_RST_CNT_RST    7'h00
`define FF_DATA_RST       8'h00
// least word distance from write to read, in cycles
`define FF_WR_RD_GAP      16

`endif

/* rtl/field_mem_array.v */
// storage array of the field fifo: one write port, one combinational read port
`timescale 1ns/1ps
`include "field_fifo_consts.vh"
module field_mem_array #(
   parameter ADDR_W = `FF_ADDR_W,
   parameter DATA_W = `FF_DATA_W
) (
   input  wire              clk,
   input  wire              wrStrobe,
   input  wire [ADDR_W-1:0] wrAddr,
   input  wire [DATA_W-1:0] wrData,
   input  wire [ADDR_W-1:0] rdAddr,
   output wire [DATA_W-1:0] rdData
);

   reg [DATA_W-1:0] memCells [0:(1<<ADDR_W)-1];

   // store one word per strobed edge
   always @(posedge clk) begin
      if (wrStrobe) begin
         memCells[wrAddr] <= wrData;
      end
   end

   // read is combinational; the caller registers it
   assign rdData = memCells[rdAddr];

endmodule // field_mem_array

/* rtl/field_fifo_core.v */
// single-channel line-delay fifo: write side, read side, init and reset tracking
//
// Function
// RULE1 - host gives 100 reset cycles each side
// RULE2 - after init pulse, 100 reset cycles each
// RULE3 - reset cycles may be split up
// RULE4 - device initializes itself on power-on reset
// RULE5 - init pulse held low when unused
// RULE6 - slow supply needs 200 ns init pulse
// RULE7 - init pulse always accepted by device
// RULE8 - read a word 16 cycles after writing
// RULE9 - stopped clocks need 16 more cycles
// RULE10 - read n only after write n+15
// RULE11 - read word presented at cycle's first edge
// RULE12 - write word captured at cycle's ending edge
// RULE13 - write clear and enable in any combination
// RULE14 - read clear and enable in any combination
// RULE15 - one-line delay word held until overlap
// RULE16 - write enable low stores and increments
// RULE17 - read enable high holds, outputs float
// RULE18 - counters span 262144, clear to zero
`timescale 1ns/1ps
`include "field_fifo_consts.vh"
module field_fifo_core #(
   parameter ADDR_W = `FF_ADDR_W,
   parameter DATA_W = `FF_DATA_W
) (
   input  wire              clk,
   input  wire              srst,
   input  wire              initPulseIn,
   input  wire              wrEnableN,
   input  wire              wrAddrClearN,
   input  wire [DATA_W-1:0] wrData,
   input  wire              rdEnableN,
   input  wire              rdAddrClearN,
   output wire [DATA_W-1:0] rdData,
   output wire              rdDataOe,
   output wire              initReady
);

   // internal initialization: power-on reset or external pulse
   wire initNow;

   // write side state
   reg  [ADDR_W-1:0] wrAddr_ff;
   reg  [ADDR_W-1:0] nxt_wrAddr;
   reg               wrPend_ff;
   reg  [ADDR_W-1:0] wrPendAddr_ff;
   reg  [ADDR_W-1:0] wrCycAddr;

   // read side state
   reg  [ADDR_W-1:0] rdAddr_ff;
   reg  [ADDR_W-1:0] nxt_rdAddr;
   reg  [ADDR_W-1:0] rdCycAddr;
   reg  [DATA_W-1:0] rdData_ff;
   reg               rdDataOe_ff;
   wire [DATA_W-1:0] memRdData;

   // reset cycle tracking
   reg  [6:0]        wrRstCnt_ff;
   reg  [6:0]        rdRstCnt_ff;
   reg               initReady_ff;
   wire              wrRstDone;
   wire              rdRstDone;

   assign initNow = srst | initPulseIn; // RULE4 RULE7

   // write cycle address: a clear in the same cycle points the access at zero
   always @* begin
      wrCycAddr  = wrAddrClearN ? wrAddr_ff : `FF_ADDR_RST; // RULE13 RULE18
      nxt_wrAddr = wrCycAddr;
      if (!wrEnableN) begin
         nxt_wrAddr = wrCycAddr + {{(ADDR_W-1){1'b0}}, 1'b1}; // RULE16
      end
   end

   // write address counter and pending capture
   always @(posedge clk) begin
      if (initNow) begin
         wrAddr_ff     <= `FF_ADDR_RST;
         wrPend_ff     <= 1'b0;
         wrPendAddr_ff <= `FF_ADDR_RST;
      end else begin
         wrAddr_ff     <= nxt_wrAddr;     // RULE16 RULE18
         wrPend_ff     <= ~wrEnableN;     // RULE12
         wrPendAddr_ff <= wrCycAddr;
      end
   end

   // read cycle address: same clear handling as the write side
   always @* begin
      rdCycAddr  = rdAddrClearN ? rdAddr_ff : `FF_ADDR_RST; // RULE14 RULE18
      nxt_rdAddr = rdCycAddr;
      if (!rdEnableN) begin
         nxt_rdAddr = rdCycAddr + {{(ADDR_W-1){1'b0}}, 1'b1};
      end
   end

   // read address counter and output register
   always @(posedge clk) begin
      if (initNow) begin
         rdAddr_ff   <= `FF_ADDR_RST;
         rdData_ff   <= `FF_DATA_RST;
         rdDataOe_ff <= 1'b0;
      end else begin
         rdAddr_ff   <= nxt_rdAddr;       // RULE17
         rdDataOe_ff <= ~rdEnableN;       // RULE17
         if (!rdEnableN) begin
            rdData_ff <= memRdData;       // RULE11
         end
      end
   end

   // word array; the write lands one edge after enable was sampled
   field_mem_array #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_mem (
      .clk      (clk),
      .wrStrobe (wrPend_ff & ~initNow),   // RULE12
      .wrAddr   (wrPendAddr_ff),
      .wrData   (wrData),
      .rdAddr   (rdCycAddr),
      .rdData   (memRdData)
   );

   assign wrRstDone = (wrRstCnt_ff == `FF_RST_CYC_MIN);
   assign rdRstDone = (rdRstCnt_ff == `FF_RST_CYC_MIN);

   // count reset cycles on each side, need not be consecutive
   always @(posedge clk) begin
      if (initNow) begin
         wrRstCnt_ff  <= `FF_RST_CNT_RST;
         rdRstCnt_ff  <= `FF_RST_CNT_RST;
         initReady_ff <= 1'b0;
      end else begin
         if (!wrAddrClearN && !wrRstDone) begin
            wrRstCnt_ff <= wrRstCnt_ff + 7'h01; // RULE1 RULE2 RULE3
         end
         if (!rdAddrClearN && !rdRstDone) begin
            rdRstCnt_ff <= rdRstCnt_ff + 7'h01; // RULE1 RULE2 RULE3
         end
         initReady_ff <= wrRstDone & rdRstDone;
      end
   end

   // outputs come straight from flops
   assign rdData    = rdData_ff;
   assign rdDataOe  = rdDataOe_ff;  // low means the data pins float
   assign initReady = initReady_ff;

endmodule // field_fifo_core

/* verification/field_fifo_checker_asserts.sv */
// port checker for the field fifo core
`timescale 1ns/1ps
module field_fifo_checker (
   input wire logic       clk,
   input wire logic       srst,
   input wire logic       initPulseIn,
   input wire logic       wrEnableN,
   input wire logic       wrAddrClearN,
   input wire logic [7:0] wrData,
   input wire logic       rdEnableN,
   input wire logic       rdAddrClearN,
   input wire logic [7:0] rdData,
   input wire logic       rdDataOe,
   input wire logic       initReady
);
   logic       wz_ff, pend_ff, ok_ff;
   logic [7:0] w0_ff;
   wire        rs = srst | initPulseIn;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // shadow of the word stored at write address zero
   always @(posedge clk) begin
      wz_ff <= rs | wrEnableN & (!wrAddrClearN | wz_ff);
      pend_ff <= !rs & !wrEnableN & (!wrAddrClearN | wz_ff);
      ok_ff <= !rs & (ok_ff | pend_ff);
      if (pend_ff & !rs) w0_ff <= wrData;
   end
   a_oe_lag: assert property (!$past(rs) |-> rdDataOe != $past(rdEnableN))
      else $error("oe");
   a_idle_float: assert property (rdEnableN & !rs |=> !rdDataOe) else $error("float");
   a_data_hold: assert property ($past(rdEnableN) & !$past(rs) |-> $stable(rdData))
      else $error("hold");
   a_rst_quiet: assert property ($past(srst) |-> !rdDataOe & !initReady & ~|rdData)
      else $error("reset");
   a_init_quiet: assert property (initPulseIn |=> !rdDataOe & !initReady & ~|rdData)
      else $error("init");
   a_ready_cause: assert property ($rose(initReady) |->
      !$past(wrAddrClearN, 2) | !$past(rdAddrClearN, 2)) else $error("ready");
   a_ready_keep: assert property (initReady & !rs |=> initReady) else $error("keep");
   a_zero_read: assert property (!rs & !rdEnableN & !rdAddrClearN & ok_ff
      |=> rdData == $past(w0_ff)) else $error("data");
   c_ready: cover property ($rose(initReady));
   c_pulse: cover property (initPulseIn);
   c_zero: cover property (!rdEnableN & !rdAddrClearN & ok_ff);
endmodule // field_fifo_checker
bind field_fifo_core field_fifo_checker chk (.clk(clk), .srst(srst), .initPulseIn(initPulseIn),
   .wrEnableN(wrEnableN), .wrAddrClearN(wrAddrClearN), .wrData(wrData),
   .rdEnableN(rdEnableN), .rdAddrClearN(rdAddrClearN), .rdData(rdData),
   .rdDataOe(rdDataOe), .initReady(initReady));

/* verification/fifo_host_model.sv */
// host model: init clear bursts split by a gap
`timescale 1ns/1ps
module fifo_host_model (
   input  wire logic clk,
   input  wire logic go,
   output wire logic clrN
);
   logic [7:0] cnt_ff;
   // 50 clear cycles, 10 idle, 50 more
   always @(posedge clk) begin
      if (go) cnt_ff <= 8'h00;
      else if (cnt_ff != 8'h6e) cnt_ff <= cnt_ff + 8'h01;
   end
   assign clrN = cnt_ff > 8'h6d | cnt_ff > 8'h31 & cnt_ff < 8'h3c;
endmodule // fifo_host_model

/* verification/field_fifo_init_and_latency_test.sv */
// self-checking bench for the field fifo core
`timescale 1ns/1ps
module field_fifo_init_and_latency_test;
   // init pulse rests low outside its use
   logic       clk = 0, srst = 1, go = 1, initPulseIn = 0;
   logic       wrEnableN = 1, rdEnableN = 1, wClrN = 1, rClrN = 1;
   logic [7:0] wrData = 8'h00;
   wire  [7:0] rdData;
   wire        clrN, rdDataOe, initReady;
   int         err_count = 0, checked = 0, cyc = 0;
   // 4 ns clock; host model feeds both clears
   always #2 clk = !clk;
   fifo_host_model host (.clk, .go, .clrN);
   field_fifo_core uut (.clk, .srst, .initPulseIn, .wrEnableN, .wrAddrClearN(wClrN & clrN),
      .wrData, .rdEnableN, .rdAddrClearN(rClrN & clrN), .rdData, .rdDataOe, .initReady);
   task chk(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // run needs about 390 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         stop_test();
      end
   end
   task t_init;
      @(posedge clk) go <= 1;
      @(posedge clk) go <= 0;
      repeat (60) @(posedge clk);
      @(negedge clk) chk("initReady", 0, initReady);
      repeat (60) @(posedge clk);
      @(negedge clk) chk("initReady", 1, initReady);
      $display("init done");
   endtask
   task rd(int s, int n);
      for (int j = 0; j <= n; j++) begin
         @(posedge clk) rdEnableN <= j == n;
         rClrN <= !(s == 0 && j == 0);
         @(negedge clk) if (j > 0) chk("rdData", 8'h0f + 8'(s + j), rdData);
         if (j > 0) chk("rdDataOe", 1, rdDataOe);
      end
   endtask
   task t_stream;
      @(posedge clk) wClrN <= 0;
      for (int j = 0; j <= 20; j++) begin
         @(posedge clk) wClrN <= 1;
         wrEnableN <= j == 20;
         wrData <= 8'h0f + 8'(j);
      end
      rd(0, 10);
      @(posedge clk);
      @(negedge clk) chk("rdDataOe", 0, rdDataOe);
      chk("rdData", 8'h19, rdData);
      rd(10, 10);
      $display("stream done");
   endtask
   task t_pulse;
      @(posedge clk) initPulseIn <= 1;
      repeat (50) @(posedge clk);
      initPulseIn <= 0;
      @(negedge clk) chk("initReady", 0, initReady);
      t_init();
      $display("pulse done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 0;
      t_init();
      t_stream();
      t_pulse();
      t_stream();
      stop_test();
   end
endmodule // field_fifo_init_and_latency_test
